// ---- logic/seq_map.svh ----
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
// =====================================================================
// Register byte offsets on the APB side.
`define OFS_CMD 8'h00
`define OFS_FLAGS 8'h04
`define OFS_WP 8'h08
`define OFS_PC 8'h0C
`define OFS_TRAP 8'h10
`define OFS_STATE 8'h14
`define OFS_DATA 8'h18
// =====================================================================
// Command word fields.
`define CMD_CODE_LSB 0
`define CMD_WR_BIT 3
`define CMD_WS_BIT 4
`define CMD_LOCK_BIT 5
`define CMD_EOI_BIT 6
`define CMD_INT_BIT 7
`define CMD_ADDR_LSB 16
// Trap register bits.
`define TRAP_BAD_BIT 0
`define TRAP_ARITH_BIT 1
`define TRAP_PRIV_BIT 2
// =====================================================================
// Status codes with the memory strobe low.
`define BST_LOCKED_SOURCE_READ_CODE 3'h0
`define BST_IOP 3'h1
`define BST_IAQ 3'h2
`define BST_SOP 3'h3
`define BST_DOP 3'h4
`define BST_VECTOR_FETCH_CODE 3'h5
`define BST_WS 3'h6
`define BST_GM 3'h7
// Status codes with the memory strobe high.
`define BST_LOCKED_INTERNAL_CYCLE_CODE 3'h0
`define BST_INTERNAL_CYCLE_CODE 3'h1
`define BST_BUS_SURRENDER_CODE 3'h7
// =====================================================================
// Vectors, masks and workspace save offsets.
`define VEC_RESET 16'h0000
`define VEC_NMI 16'hFFFC
`define VEC_TRAP 16'h0008
`define VEC_STEP 16'h0002
`define MASK_TOP 4'h0
`define MASK_TRAP 4'h1
`define SAVE_WP_OFS 16'h001A
`define SAVE_PC_OFS 16'h001C
`define SAVE_ST_OFS 16'h001E
// Flags word: mask field and the bits cleared on a switch.
`define FLAGS_RST 16'h0000
`define FLAGS_CLR 16'h01F0
`define FLAGS_AIE_BIT 5
// =====================================================================
// Bus cycle timing.
`define CLK_NS 10
`define CYC_NS 40
`define CYC_CLKS (`CYC_NS / `CLK_NS)
`endif

// ---- logic/seq_pkg.sv ----
`default_nettype none
package seq_pkg;
  // ===================================================================
  // Sequencer states.
  typedef enum logic [3:0] {
    S_IDLE, S_CYC, S_LOCK_SRC, S_LOCK_INT, S_HOLD,
    S_VEC_WP, S_VEC_PC, S_SAVE_WP, S_SAVE_PC, S_SAVE_ST
  } state_type;

  // Interrupt source picked by the arbiter.
  typedef enum logic [1:0] {SRC_EXT, SRC_NMI, SRC_TRAP} src_type;

  // Whole state of the sequencer.
  typedef struct packed {
    state_type st;
    logic [1:0] cnt;
    logic mem_n;
    logic [2:0] code;
    logic latch;
    logic psel;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] flags;
    logic [15:0] wp;
    logic [15:0] pc;
    logic [15:0] vec;
    logic [15:0] nwp;
    logic [3:0] mask_new;
    logic rst_pend;
    logic nmi_pend;
    logic nmi_prev;
    logic t_bad;
    logic t_arith;
    logic t_priv;
    logic inhibit;
    logic eoi;
    logic iaq_cyc;
    logic after_iaq;
    logic lock_ws;
    logic s_req;
    logic [3:0] s_lvl;
    logic discard;
    logic [31:0] prdata;
  } regs_type;
endpackage : seq_pkg
`default_nettype wire

// ---- logic/pin_sync.sv ----
`default_nettype none
// =====================================================================
// Two flip-flop synchroniser for asynchronous pins.
module pin_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = '1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Raw pins and their synchronised copy.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage; only the second stage reads it.
  logic [W-1:0] meta;

  // Both stages reset to the idle pin level.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ---- logic/irq_arbiter.sv ----
`default_nettype none
`include "seq_map.svh"
// =====================================================================
// Picks the winning interrupt and its vector and new mask.
module irq_arbiter (
  // Pending sources.
  input wire logic req,
  input wire logic [3:0] lvl,
  input wire logic nmi,
  input wire logic t_bad,
  input wire logic t_arith,
  input wire logic t_priv,
  // Current flags state.
  input wire logic [3:0] mask,
  input wire logic aie,
  // Decision.
  output logic take,
  output logic [15:0] vec,
  output logic [3:0] mask_out,
  output seq_pkg::src_type src
);
  import seq_pkg::*;

  // An enabled internal trap is waiting.
  logic trap;
  // External maskable requests are held off.
  logic ignore_ext;

  assign trap = t_bad | (t_arith & aie) | t_priv;
  assign ignore_ext = (t_arith & aie) | t_priv;

  // Fixed priority: unmaskable, then traps, then the pins.
  always_comb begin
    take = 1'b0;
    vec = `VEC_RESET;
    mask_out = `MASK_TOP;
    src = SRC_EXT;
    if (nmi) begin
      take = 1'b1;
      vec = `VEC_NMI;
      src = SRC_NMI;
    end else if (trap) begin
      take = 1'b1;
      vec = `VEC_TRAP;
      mask_out = `MASK_TRAP;
      src = SRC_TRAP;
    end else if (req && !ignore_ext && (lvl <= mask || lvl == 4'h0)) begin
      take = 1'b1;
      vec = {10'h000, lvl, 2'b00};
      mask_out = (lvl == 4'h0) ? `MASK_TOP : lvl - 4'h1;
    end
  end
endmodule : irq_arbiter
`default_nettype wire

// ---- logic/bus_status_and_interrupt_sequencer.sv ----
// The address map and the APB interface to the registers were left to the implementer.
`default_nettype none
`include "seq_map.svh"
// =====================================================================
// Bus status and interrupt sequencer.
module bus_status_and_interrupt_sequencer (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous device pins, active low where named so.
  input wire logic hold_req_n,
  input wire logic coprocessor_present_input_n,
  input wire logic irq_request_n,
  input wire logic [3:0] irq_level_lines,
  input wire logic nmi_n,
  // Read data returned by the memory cycle logic.
  input wire logic [15:0] bus_rdata,
  // Bus cycle outputs.
  output logic mem_n,
  output logic [2:0] status_code_bits,
  output logic address_capture_pulse,
  output logic page_select,
  output logic bus_write,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_wdata,
  output logic prefetch_discard
);
  import seq_pkg::*;

  // ===================================================================
  // Constants and state.
  localparam logic [1:0] CNT_LAST = 2'(`CYC_CLKS - 1);

  // Power-up value: reset vector fetch is owed.
  localparam regs_type R0 = '{
    st: S_IDLE,
    mem_n: 1'b1,
    code: `BST_INTERNAL_CYCLE_CODE,
    flags: `FLAGS_RST,
    rst_pend: 1'b1,
    default: '0
  };

  // Registered state and its next value.
  regs_type r_r;
  regs_type r_nxt;

  // Synchronised pins, active high.
  logic [7:0] pins;
  logic hold_s;
  logic cop_s;
  logic req_s;
  logic [3:0] lvl_s;
  logic nmi_s;

  // Bus decode.
  logic acc;
  logic wr_en;
  logic mapped;
  logic cmd_go;

  // Sampling window and cycle end.
  logic samp_open;
  logic last;

  // Arbiter answer.
  logic take;
  logic [15:0] tvec;
  logic [3:0] tmask;
  src_type tsrc;

  // Command fields.
  logic [2:0] c_code;
  logic c_ws;
  logic c_mem_n;

  // ===================================================================
  // Pin synchronisers; no logic reads the first stage.
  pin_sync #(
    .W(8),
    .INIT(8'hFF)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({hold_req_n, coprocessor_present_input_n, irq_request_n,
        irq_level_lines, nmi_n}),
    .q(pins)
  );

  assign hold_s = ~pins[7];
  assign cop_s = ~pins[6];
  assign req_s = ~pins[5];
  assign lvl_s = pins[4:1];
  assign nmi_s = ~pins[0];

  // ===================================================================
  // Interrupt arbitration on the last sample taken.
  irq_arbiter u_arb (
    .req(r_r.s_req),
    .lvl(r_r.s_lvl),
    .nmi(r_r.nmi_pend),
    .t_bad(r_r.t_bad),
    .t_arith(r_r.t_arith),
    .t_priv(r_r.t_priv),
    .mask(r_r.flags[3:0]),
    .aie(r_r.flags[`FLAGS_AIE_BIT]),
    .take(take),
    .vec(tvec),
    .mask_out(tmask),
    .src(tsrc)
  );

  // ===================================================================
  // APB decode: zero wait states, error on unmapped offsets.
  assign acc = psel & penable;
  assign wr_en = acc & pwrite;
  assign mapped = (paddr == `OFS_CMD) || (paddr == `OFS_FLAGS) ||
                  (paddr == `OFS_WP) || (paddr == `OFS_PC) ||
                  (paddr == `OFS_TRAP) || (paddr == `OFS_STATE) ||
                  (paddr == `OFS_DATA);
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = r_r.prdata;

  // A command only starts from idle with nothing more urgent owed.
  assign cmd_go = wr_en && paddr == `OFS_CMD && r_r.st == S_IDLE &&
                  !r_r.rst_pend && !hold_s && !cop_s;

  // ===================================================================
  // Command decode into a status code.
  always_comb begin
    c_ws = pwdata[`CMD_WS_BIT];
    c_mem_n = pwdata[`CMD_INT_BIT];
    c_code = pwdata[`CMD_CODE_LSB +: 3];
    if (!c_mem_n) begin
      // Register-file code follows addressing mode only.
      if (c_ws) begin
        c_code = `BST_WS;
      end else if (c_code == `BST_WS) begin
        c_code = `BST_GM;
      end else if (c_code == `BST_LOCKED_SOURCE_READ_CODE) begin
        // The lock code is kept for the locking sequence.
        c_code = `BST_SOP;
      end
    end else begin
      // Internal cycles carry only the unlocked internal code.
      c_code = `BST_INTERNAL_CYCLE_CODE;
    end
  end

  // ===================================================================
  // Cycle bookkeeping.
  assign last = r_r.cnt == CNT_LAST;

  // Sampling runs from the fetch until one clock before the next
  // cycle ends; it is shut from a switch until the first end-of-instruction cycle ends.
  assign samp_open = !r_r.inhibit && (r_r.iaq_cyc ||
                     (r_r.after_iaq && !last && r_r.st != S_IDLE));

  // Opens a new bus cycle with its capture pulse.
  function automatic regs_type start_cyc(
    input regs_type s,
    input state_type st,
    input logic mn,
    input logic [2:0] c,
    input logic w,
    input logic [15:0] a,
    input logic [15:0] d
  );
    regs_type t;
    t = s;
    t.st = st;
    t.cnt = 2'h0;
    t.latch = 1'b1;
    t.mem_n = mn;
    t.code = c;
    t.wr = w;
    t.addr = a;
    t.wdata = d;
    t.psel = 1'b0;
    return t;
  endfunction : start_cyc

  // ===================================================================
  // Next-state logic for the whole sequencer.
  always_comb begin
    r_nxt = r_r;
    r_nxt.latch = 1'b0;
    r_nxt.discard = 1'b0;

    // Only the last sample in the window counts.
    if (samp_open) begin
      r_nxt.s_req = req_s;
      r_nxt.s_lvl = lvl_s;
    end

    // Cycle counter runs in every state but idle and hold.
    if (r_r.st != S_IDLE && r_r.st != S_HOLD) begin
      r_nxt.cnt = r_r.cnt + 2'h1;
    end

    case (r_r.st)
      S_IDLE: begin
        if (r_r.rst_pend) begin
          // Reset switch through level 0 vector.
          r_nxt = start_cyc(r_nxt, S_VEC_WP, 1'b0, `BST_VECTOR_FETCH_CODE, 1'b0,
                            `VEC_RESET, r_r.wdata);
          r_nxt.psel = 1'b1;
          r_nxt.vec = `VEC_RESET;
          r_nxt.mask_new = `MASK_TOP;
          r_nxt.rst_pend = 1'b0;
        end else if (hold_s || cop_s) begin
          r_nxt = start_cyc(r_nxt, S_HOLD, 1'b1, `BST_BUS_SURRENDER_CODE, 1'b1,
                            r_r.addr, r_r.wdata);
        end else if (cmd_go && pwdata[`CMD_LOCK_BIT]) begin
          // Locking op: lock read unless source is a register.
          r_nxt = start_cyc(r_nxt, S_LOCK_SRC, 1'b0,
                            c_ws ? `BST_WS : `BST_LOCKED_SOURCE_READ_CODE, 1'b0,
                            pwdata[`CMD_ADDR_LSB +: 16], r_r.wdata);
          r_nxt.lock_ws = c_ws;
          r_nxt.eoi = 1'b0;
        end else if (cmd_go) begin
          r_nxt = start_cyc(r_nxt, S_CYC, c_mem_n, c_code,
                            pwdata[`CMD_WR_BIT] & ~c_mem_n,
                            pwdata[`CMD_ADDR_LSB +: 16], r_r.wdata);
          r_nxt.eoi = pwdata[`CMD_EOI_BIT];
          r_nxt.iaq_cyc = !c_mem_n && !pwdata[`CMD_WR_BIT] &&
                          c_code == `BST_IAQ;
        end
      end

      S_CYC: begin
        if (last) begin
          // Cycle over: the code drops back to internal.
          r_nxt.st = S_IDLE;
          r_nxt.mem_n = 1'b1;
          r_nxt.code = `BST_INTERNAL_CYCLE_CODE;
          r_nxt.wr = 1'b0;
          r_nxt.after_iaq = r_r.iaq_cyc;
          r_nxt.iaq_cyc = 1'b0;
          r_nxt.eoi = 1'b0;
          if (r_r.eoi && r_r.inhibit) begin
            r_nxt.inhibit = 1'b0;
          end else if (r_r.eoi && take) begin
            // Accept at the instruction boundary.
            r_nxt.discard = 1'b1;
            r_nxt = start_cyc(r_nxt, S_VEC_WP, 1'b0, `BST_VECTOR_FETCH_CODE, 1'b0,
                              tvec, r_r.wdata);
            r_nxt.psel = 1'b1;
            r_nxt.vec = tvec;
            r_nxt.mask_new = tmask;
            r_nxt.s_req = 1'b0;
            r_nxt.after_iaq = 1'b0;
            if (tsrc == SRC_NMI) begin
              r_nxt.nmi_pend = 1'b0;
            end
            if (tsrc == SRC_TRAP) begin
              r_nxt.t_bad = 1'b0;
              r_nxt.t_arith = 1'b0;
              r_nxt.t_priv = 1'b0;
            end
          end
        end
      end

      S_LOCK_SRC: begin
        if (hold_s && !r_r.lock_ws) begin
          // Hold still wins while locked.
          r_nxt = start_cyc(r_nxt, S_HOLD, 1'b1, `BST_BUS_SURRENDER_CODE, 1'b1,
                            r_r.addr, r_r.wdata);
        end else if (last) begin
          r_nxt = start_cyc(r_nxt, S_LOCK_INT, 1'b1,
                            r_r.lock_ws ? `BST_INTERNAL_CYCLE_CODE : `BST_LOCKED_INTERNAL_CYCLE_CODE, 1'b0,
                            r_r.addr, r_r.wdata);
        end
      end

      S_LOCK_INT: begin
        if (hold_s && !r_r.lock_ws) begin
          r_nxt = start_cyc(r_nxt, S_HOLD, 1'b1, `BST_BUS_SURRENDER_CODE, 1'b1,
                            r_r.addr, r_r.wdata);
        end else if (last) begin
          // Lock drops as the write-back cycle opens.
          r_nxt = start_cyc(r_nxt, S_CYC, 1'b0,
                            r_r.lock_ws ? `BST_WS : `BST_SOP, 1'b1,
                            r_r.addr, r_r.wdata);
          r_nxt.eoi = 1'b1;
        end
      end

      S_HOLD: begin
        if (!hold_s && !cop_s) begin
          r_nxt.st = S_IDLE;
          r_nxt.code = `BST_INTERNAL_CYCLE_CODE;
          r_nxt.wr = 1'b0;
        end
      end

      S_VEC_WP: begin
        if (last) begin
          r_nxt.nwp = bus_rdata;
          r_nxt = start_cyc(r_nxt, S_VEC_PC, 1'b0, `BST_VECTOR_FETCH_CODE, 1'b0,
                            r_r.vec + `VEC_STEP, r_r.wdata);
          r_nxt.psel = 1'b1;
        end
      end

      S_VEC_PC: begin
        if (last) begin
          // New counter parks in the vector field until saved.
          r_nxt.vec = bus_rdata;
          r_nxt = start_cyc(r_nxt, S_SAVE_WP, 1'b0, `BST_WS, 1'b1,
                            r_r.nwp + `SAVE_WP_OFS, r_r.wp);
        end
      end

      S_SAVE_WP: begin
        if (last) begin
          r_nxt = start_cyc(r_nxt, S_SAVE_PC, 1'b0, `BST_WS, 1'b1,
                            r_r.nwp + `SAVE_PC_OFS, r_r.pc);
        end
      end

      S_SAVE_PC: begin
        if (last) begin
          r_nxt = start_cyc(r_nxt, S_SAVE_ST, 1'b0, `BST_WS, 1'b1,
                            r_r.nwp + `SAVE_ST_OFS, r_r.flags);
        end
      end

      S_SAVE_ST: begin
        if (last) begin
          r_nxt.st = S_IDLE;
          r_nxt.mem_n = 1'b1;
          r_nxt.code = `BST_INTERNAL_CYCLE_CODE;
          r_nxt.wr = 1'b0;
          r_nxt.wp = r_r.nwp;
          r_nxt.pc = r_r.vec;
          r_nxt.flags = {r_r.flags[15:4], r_r.mask_new} & ~`FLAGS_CLR;
          r_nxt.inhibit = 1'b1;
        end
      end

      default: begin
        r_nxt.st = S_IDLE;
      end
    endcase

    // Unmaskable request is taken on its falling pin edge only.
    // It is set after the arbiter's clear so a new edge is never lost.
    r_nxt.nmi_prev = nmi_s;
    if (nmi_s && !r_r.nmi_prev) begin
      r_nxt.nmi_pend = 1'b1;
    end

    // Software writes; a trap set here beats a clear above.
    if (wr_en) begin
      case (paddr)
        `OFS_FLAGS: r_nxt.flags = pwdata[15:0];
        `OFS_WP: r_nxt.wp = pwdata[15:0];
        `OFS_PC: r_nxt.pc = pwdata[15:0];
        `OFS_DATA: begin
          if (r_r.st == S_IDLE) begin
            r_nxt.wdata = pwdata[15:0];
          end
        end
        `OFS_TRAP: begin
          r_nxt.t_bad = r_nxt.t_bad | pwdata[`TRAP_BAD_BIT];
          r_nxt.t_arith = r_nxt.t_arith | pwdata[`TRAP_ARITH_BIT];
          r_nxt.t_priv = r_nxt.t_priv | pwdata[`TRAP_PRIV_BIT];
        end
        default: begin
        end
      endcase
    end

    // Read data is captured in the setup phase.
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFS_CMD: r_nxt.prdata = {31'h0, r_r.st != S_IDLE};
        `OFS_FLAGS: r_nxt.prdata = {16'h0, r_r.flags};
        `OFS_WP: r_nxt.prdata = {16'h0, r_r.wp};
        `OFS_PC: r_nxt.prdata = {16'h0, r_r.pc};
        `OFS_TRAP: r_nxt.prdata = {29'h0, r_r.t_priv, r_r.t_arith, r_r.t_bad};
        `OFS_STATE: r_nxt.prdata = {16'h0, r_r.s_lvl, r_r.s_req, r_r.nmi_pend,
                                    r_r.inhibit, r_r.st, r_r.mem_n, 1'b0, r_r.code};
        `OFS_DATA: r_nxt.prdata = {16'h0, r_r.wdata};
        default: r_nxt.prdata = 32'h0;
      endcase
    end
  end

  // ===================================================================
  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= R0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ===================================================================
  // Outputs straight from the state register.
  assign mem_n = r_r.mem_n;
  assign status_code_bits = r_r.code;
  assign address_capture_pulse = r_r.latch;
  assign page_select = r_r.psel;
  assign bus_write = r_r.wr;
  assign bus_addr = r_r.addr;
  assign bus_wdata = r_r.wdata;
  assign prefetch_discard = r_r.discard;
endmodule : bus_status_and_interrupt_sequencer
`default_nettype wire

// ---- verification/seq_chk.sv ----
`default_nettype none
// ==========
// Port checks on the bus status and interrupt sequencer.
module seq_chk (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Watched pins.
  input wire logic hold_req_n,
  input wire logic mem_n,
  input wire logic [2:0] status_code_bits,
  input wire logic address_capture_pulse,
  input wire logic page_select,
  input wire logic bus_write,
  input wire logic prefetch_discard
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Cycle coding.
  code_holds_a: assert property (address_capture_pulse |=>
    ($stable(status_code_bits) && $stable(mem_n) && !address_capture_pulse)[*3])
    else $error("status code moved inside a cycle");
  write_kind_a: assert property (!mem_n && bus_write |->
    status_code_bits inside {3'h3, 3'h4, 3'h6, 3'h7}) else $error("bad write code");
  internal_a: assert property (mem_n && !bus_write |->
    status_code_bits inside {3'h0, 3'h1}) else $error("bad internal code");
  hold_a: assert property ($fell(hold_req_n) |->
    ##[1:10] (mem_n && bus_write && status_code_bits == 3'h7)) else $error("no hold code");
  // The lock must span exactly the read and the internal cycle.
  lock_seq_a: assert property (address_capture_pulse && !mem_n && status_code_bits == 3'h0
    |-> ##4 (mem_n && status_code_bits == 3'h0) ##4 (status_code_bits == 3'h3))
    else $error("lock sequence broken");
  // ==========
  // Interrupt sequencing.
  vec_page_a: assert property (page_select |-> !mem_n && status_code_bits == 3'h5)
    else $error("page select outside vector fetch");
  discard_a: assert property (prefetch_discard |->
    (address_capture_pulse && page_select)) else $error("no vector after discard");
  save_a: assert property ((address_capture_pulse && page_select) ##4
    (address_capture_pulse && page_select) |-> ##4 (address_capture_pulse && !mem_n &&
    bus_write && status_code_bits == 3'h6)) else $error("no context save");
  lock_c: cover property (address_capture_pulse && !mem_n && status_code_bits == 3'h0);
  hold_c: cover property (mem_n && status_code_bits == 3'h7);
  take_c: cover property (prefetch_discard);
endmodule : seq_chk
bind bus_status_and_interrupt_sequencer seq_chk seq_chk_u (.pclk, .presetn, .hold_req_n,
  .mem_n, .status_code_bits, .address_capture_pulse, .page_select, .bus_write,
  .prefetch_discard);
`default_nettype wire

// ---- verification/seq_partner.sv ----
`default_nettype none
// ==========
// Memory, interrupting device and DMA master on the far side.
module seq_partner (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bus pins of the sequencer.
  input wire logic mem_n,
  input wire logic [2:0] status_code_bits,
  input wire logic address_capture_pulse,
  input wire logic page_select,
  input wire logic bus_write,
  input wire logic [15:0] bus_addr,
  // Bench controls.
  input wire logic req_go,
  input wire logic req_stop,
  input wire logic [3:0] req_lvl,
  input wire logic hold_on,
  // Pins driven back.
  output logic [15:0] bus_rdata,
  output logic irq_request_n,
  output logic [3:0] irq_level_lines,
  output logic hold_req_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Memory word is its low address byte over a fixed byte; idle data toggles.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_rdata <= 16'h0000;
      irq_request_n <= 1'b1;
      irq_level_lines <= 4'h0;
      hold_req_n <= 1'b1;
    end else begin
      bus_rdata <= (!mem_n && !bus_write) ? {bus_addr[7:0], 8'h40} : ~bus_rdata;
      // Level held with the request; dropped on its own vector fetch.
      if (req_go) begin
        irq_request_n <= 1'b0;
        irq_level_lines <= req_lvl;
      end else if (req_stop || (address_capture_pulse && page_select &&
          bus_addr == {10'h000, irq_level_lines, 2'b00})) begin
        irq_request_n <= 1'b1;
      end
      // No hold is asked while the lock code shows.
      hold_req_n <= !(hold_on && status_code_bits != 3'h0);
    end
  end
endmodule : seq_partner
`default_nettype wire

// ---- verification/tb.sv ----
`default_nettype none
`include "seq_map.svh"
// ==========
// Bench top: APB tasks and scenarios.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq_request_n, hold_req_n, mem_n;
  logic address_capture_pulse, page_select, bus_write, prefetch_discard;
  logic [3:0] irq_level_lines;
  logic [15:0] bus_rdata, bus_addr, bus_wdata;
  logic [2:0] status_code_bits;
  logic req_go = 1'b0;
  logic req_stop = 1'b0;
  logic hold_on = 1'b0;
  logic [3:0] req_lvl = 4'h0;
  // Last cycle seen and counts of lock and discard events.
  logic [2:0] last_code = 3'h0;
  logic last_mem = 1'b0;
  logic last_wr = 1'b0;
  int lock_cnt = 0;
  int disc_cnt = 0;
  int errors = 0;
  int checks_done = 0;
  int n;
  logic [31:0] rd;
  logic serr;
  always #5 pclk = ~pclk;
  bus_status_and_interrupt_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hold_req_n(hold_req_n),
    .coprocessor_present_input_n(1'b1), .irq_request_n(irq_request_n),
    .irq_level_lines(irq_level_lines), .nmi_n(1'b1), .bus_rdata(bus_rdata),
    .mem_n(mem_n), .status_code_bits(status_code_bits),
    .address_capture_pulse(address_capture_pulse), .page_select(page_select),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .prefetch_discard(prefetch_discard));
  seq_partner partner_u (.pclk(pclk), .presetn(presetn), .mem_n(mem_n),
    .status_code_bits(status_code_bits), .address_capture_pulse(address_capture_pulse),
    .page_select(page_select), .bus_write(bus_write), .bus_addr(bus_addr), .req_go(req_go),
    .req_stop(req_stop), .req_lvl(req_lvl), .hold_on(hold_on), .bus_rdata(bus_rdata),
    .irq_request_n(irq_request_n), .irq_level_lines(irq_level_lines), .hold_req_n(hold_req_n));
  // Monitor samples design registers before they update at each edge.
  always @(posedge pclk) begin
    if (address_capture_pulse) begin
      last_code <= status_code_bits;
      last_mem <= mem_n;
      last_wr <= bus_write;
      lock_cnt <= lock_cnt + int'(status_code_bits == 3'h0);
    end
    disc_cnt <= disc_cnt + int'(prefetch_discard);
  end
  // ==========
  // Helper tasks.
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("register", rd, e);
  endtask : rchk
  // Polling is bounded so a stuck busy flag ends as a mismatch.
  task automatic idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, `OFS_CMD, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 60);
    chk("busy", rd[0], 1'b0);
  endtask : idle
  task automatic cmd(input logic [31:0] w);
    apb(1'b1, `OFS_CMD, w);
    idle();
  endtask : cmd
  // Request pulse, then time for the two-stage pin synchroniser.
  task automatic irq(input logic [3:0] l);
    req_lvl <= l;
    req_go <= 1'b1;
    @(posedge pclk);
    req_go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : irq
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // ==========
  // Watchdog: the whole run needs a few hundred cycles.
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  initial begin
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    idle();
    rchk(`OFS_WP, 32'h0040);
    rchk(`OFS_PC, 32'h0240);
    rchk(`OFS_FLAGS, 32'h0);
    $display("done: reset");
    for (int c = 1; c < 8; c++) begin
      cmd(32'h01000000 + c);
      chk("read code", {last_mem, last_code}, (c == 6) ? 7 : c);
    end
    for (int c = 3; c < 8; c++) begin
      if (c != 5) begin
        cmd(32'h01000008 + c);
        chk("write", {last_wr, last_code}, 8 + ((c == 6) ? 7 : c));
      end
    end
    n = lock_cnt;
    cmd(32'h02000020);
    chk("lock cycles", lock_cnt - n, 2);
    chk("after lock", last_code, 3'h3);
    cmd(32'h02000030);
    chk("ws lock", lock_cnt - n, 2);
    chk("ws end", last_code, 3'h6);
    cmd(32'h00000080);
    chk("internal", {last_mem, last_code}, 4'h9);
    $display("done: codes");
    apb(1'b1, `OFS_FLAGS, 32'h01F5);
    irq(4'h3);
    cmd(32'h00000042);
    chk("discard", disc_cnt, 1);
    rchk(`OFS_WP, 32'h0C40);
    rchk(`OFS_PC, 32'h0E40);
    rchk(`OFS_FLAGS, 32'h0002);
    chk("saved flags", bus_wdata, 16'h01F5);
    irq(4'h0);
    cmd(32'h00000042);
    chk("inhibit", disc_cnt, 1);
    cmd(32'h00000042);
    rchk(`OFS_WP, 32'h0040);
    irq(4'h9);
    cmd(32'h00000042);
    cmd(32'h00000042);
    chk("masked", disc_cnt, 2);
    req_stop <= 1'b1;
    apb(1'b1, `OFS_TRAP, 32'h1);
    req_stop <= 1'b0;
    cmd(32'h00000042);
    rchk(`OFS_WP, 32'h0840);
    rchk(`OFS_FLAGS, 32'h0001);
    $display("done: interrupts");
    hold_on <= 1'b1;
    repeat (12) @(posedge pclk);
    chk("hold", {mem_n, status_code_bits}, 4'hF);
    hold_on <= 1'b0;
    idle();
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", serr, 1'b1);
    chk("unmapped", rd, 32'h0);
    $display("done: hold and unmapped");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
